// file: bsi_bsr.v
// Purpose: Boundary scan register with capture, shift and preload latches
// Assumes: Strobes are one-cycle pulses on i_mclk, at most one at a time
// Notes:   Latch of the bus-enable cell presets high
`timescale 1ns/100ps
`default_nettype none
`include "bsi_defines.vh"

module bsi_bsr #(
    parameter LEN = `BSI_BSR_LEN,
    parameter OE_CELL = `BSI_OE_CELL
) (
    input wire i_mclk,
    input wire i_arst_n,
    input wire i_tlr,
    input wire i_capture,
    input wire i_shift,
    input wire i_update,
    input wire i_tdi,
    input wire [LEN-1:0] i_pins,
    output wire o_lsb,
    output reg [LEN-1:0] o_latch_reg
);

    // ****************************************
    // Shift stage and preload latch
    // ****************************************
    reg [LEN-1:0] shift_reg;

    assign o_lsb = shift_reg[0];

    always @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            shift_reg <= {LEN{1'b0}};
        end else if (i_capture) begin
            shift_reg <= i_pins;
        end else if (i_shift) begin
            // Old capture leaves at the bottom as new pattern enters the top
            shift_reg <= {i_tdi, shift_reg[LEN-1:1]};
        end
    end

    always @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_latch_reg <= {LEN{1'b0}};
            o_latch_reg[OE_CELL] <= 1'b1;
        end else if (i_tlr) begin
            o_latch_reg[OE_CELL] <= 1'b1;
        end else if (i_update) begin
            o_latch_reg <= shift_reg;
        end
    end

endmodule // bsi_bsr
`default_nettype wire

// file: bsi_ctl.sv
// Purpose: Model of the external test controller
// Assumes: Test clock stands still low between frames
// Notes: Data lines start high, as their pull-ups leave them; a scan leaves TMS low
`timescale 1ns/100ps
`default_nettype none
module bsi_ctl (
    input wire logic i_tdo,
    output logic o_tck,
    output logic o_tms,
    output logic o_tdi
);
    logic [127:0] dout;
    event got;
    initial begin
        o_tck = 1'b0;
        o_tms = 1'b1;
        o_tdi = 1'b1;
    end
    // ***
    // Test clock steps
    // ***
    // Set in low phase, taken at rise; read late, as data out moves at the fall
    task automatic step(input logic t, input logic d, output logic o);
        o_tms = t;
        o_tdi = d;
        #160 o_tck = 1'b1;
        #150 o = i_tdo;
        #10 o_tck = 1'b0;
    endtask
    task automatic tlr();
        logic o;
        repeat (5) step(1'b1, 1'b1, o);
    endtask
    // Idle, select, capture, shift n bits, update, idle
    task automatic scan(input logic ir, input int n, input logic [127:0] din);
        logic o;
        step(1'b0, 1'b1, o);
        step(1'b1, 1'b1, o);
        if (ir)
            step(1'b1, 1'b1, o);
        step(1'b0, 1'b1, o);
        step(1'b0, 1'b1, o);
        dout = '0;
        for (int j = 0; j < n; j++)
            step(j == n - 1, din[j], dout[j]);
        step(1'b1, 1'b1, o);
        step(1'b0, 1'b1, o);
        -> got;
    endtask
endmodule // bsi_ctl
`default_nettype wire

// file: bsi_defines.vh
// Purpose: Shared constants for the boundary-scan instruction logic
// Assumes: Included by bare name from every design file
// Notes:   Definitions only
`ifndef BSI_DEFINES_VH
`define BSI_DEFINES_VH

// Instruction register
`define BSI_IR_LEN 3
`define BSI_IR_CAPTURE 3'h1
`define BSI_OP_EXTEST 3'h0
`define BSI_OP_IDCODE 3'h1
`define BSI_OP_SAMPLE_Z 3'h2
`define BSI_OP_RSVD_A 3'h3
`define BSI_OP_SAMPLE 3'h4
`define BSI_OP_RSVD_B 3'h5
`define BSI_OP_RSVD_C 3'h6
`define BSI_OP_BYPASS 3'h7

// Data registers
`define BSI_ID_LEN 32
`define BSI_ID_VALUE 32'h0a5a5001
`define BSI_BSR_LEN 109
`define BSI_OE_CELL 108
`define BSI_BYPASS_CAPTURE 1'h0

`endif

// file: bsi_tap.v
// Purpose: Test access port, instruction decode and data register selection
// Assumes: Test clock is far slower than i_mclk and is sampled here
// Notes:   Test actions happen on detected test clock edges, except the TLR resets of the instruction and bus-enable latch
`timescale 1ns/100ps
`default_nettype none
`include "bsi_defines.vh"

module bsi_tap #(
    parameter BSR_LEN = `BSI_BSR_LEN,
    parameter [`BSI_ID_LEN-1:0] ID_VALUE = `BSI_ID_VALUE // Arbitrary value
) (
    input wire i_mclk,
    input wire i_arst_n,
    input wire i_tck,
    input wire i_tms,
    input wire i_tdi,
    input wire [BSR_LEN-1:0] i_pins,
    output reg o_tdo,
    output reg o_tdo_oe,
    output reg o_qbus_oe,
    output reg o_extest,
    output wire [BSR_LEN-1:0] o_bsr_drive
);

    localparam [3:0] ST_TLR = 4'hf, ST_RTI = 4'hc, ST_SEL_DR = 4'h7, ST_CAP_DR = 4'h6,
        ST_SH_DR = 4'h2, ST_EX1_DR = 4'h1, ST_PAU_DR = 4'h3, ST_EX2_DR = 4'h0,
        ST_UPD_DR = 4'h5, ST_SEL_IR = 4'h4, ST_CAP_IR = 4'he, ST_SH_IR = 4'ha,
        ST_EX1_IR = 4'h9, ST_PAU_IR = 4'hb, ST_EX2_IR = 4'h8, ST_UPD_IR = 4'hd;

    // ****************************************
    // Synchronisers
    // ****************************************
    reg tck_s1_reg, tck_s2_reg, tck_s3_reg;
    reg tms_s1_reg, tms_s2_reg, tdi_s1_reg, tdi_s2_reg;
    reg [BSR_LEN-1:0] pin_s1_reg, pin_s2_reg;

    always @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            tck_s1_reg <= 1'b0;
            tck_s2_reg <= 1'b0;
            tck_s3_reg <= 1'b0;
            tms_s1_reg <= 1'b1;
            tms_s2_reg <= 1'b1;
            tdi_s1_reg <= 1'b1;
            tdi_s2_reg <= 1'b1;
            pin_s1_reg <= {BSR_LEN{1'b0}};
            pin_s2_reg <= {BSR_LEN{1'b0}};
        end else begin
            tck_s1_reg <= i_tck;
            tck_s2_reg <= tck_s1_reg;
            tck_s3_reg <= tck_s2_reg;
            tms_s1_reg <= i_tms;
            tms_s2_reg <= tms_s1_reg;
            tdi_s1_reg <= i_tdi;
            tdi_s2_reg <= tdi_s1_reg;
            // Pins may be mid-transition; capture value not guaranteed
            pin_s1_reg <= i_pins;
            pin_s2_reg <= pin_s1_reg;
        end
    end

    wire tck_rise = tck_s2_reg & ~tck_s3_reg;
    wire tck_fall = ~tck_s2_reg & tck_s3_reg;

    // ****************************************
    // State machine
    // ****************************************
    function [3:0] next_state;
        input [3:0] st;
        input tms;
        begin
            case (st)
                ST_TLR: next_state = tms ? ST_TLR : ST_RTI;
                ST_RTI: next_state = tms ? ST_SEL_DR : ST_RTI;
                ST_SEL_DR: next_state = tms ? ST_SEL_IR : ST_CAP_DR;
                ST_CAP_DR: next_state = tms ? ST_EX1_DR : ST_SH_DR;
                ST_SH_DR: next_state = tms ? ST_EX1_DR : ST_SH_DR;
                ST_EX1_DR: next_state = tms ? ST_UPD_DR : ST_PAU_DR;
                ST_PAU_DR: next_state = tms ? ST_EX2_DR : ST_PAU_DR;
                ST_EX2_DR: next_state = tms ? ST_UPD_DR : ST_SH_DR;
                ST_UPD_DR: next_state = tms ? ST_SEL_DR : ST_RTI;
                ST_SEL_IR: next_state = tms ? ST_TLR : ST_CAP_IR;
                ST_CAP_IR: next_state = tms ? ST_EX1_IR : ST_SH_IR;
                ST_SH_IR: next_state = tms ? ST_EX1_IR : ST_SH_IR;
                ST_EX1_IR: next_state = tms ? ST_UPD_IR : ST_PAU_IR;
                ST_PAU_IR: next_state = tms ? ST_EX2_IR : ST_PAU_IR;
                ST_EX2_IR: next_state = tms ? ST_UPD_IR : ST_SH_IR;
                ST_UPD_IR: next_state = tms ? ST_SEL_DR : ST_RTI;
                default: next_state = ST_TLR;
            endcase
        end
    endfunction

    reg [3:0] state_reg;

    // Five TMS-high rising edges reach reset from any state
    always @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_reg <= ST_TLR;
        end else if (tck_rise) begin
            state_reg <= next_state(state_reg, tms_s2_reg);
        end
    end

    wire in_tlr = (state_reg == ST_TLR);

    // ****************************************
    // Instruction register
    // ****************************************
    reg [`BSI_IR_LEN-1:0] ir_sh_reg, ir_reg;

    always @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ir_sh_reg <= `BSI_OP_IDCODE;
            ir_reg <= `BSI_OP_IDCODE;
        end else if (in_tlr) begin
            ir_reg <= `BSI_OP_IDCODE;
        end else if (tck_rise) begin
            case (state_reg)
                ST_CAP_IR: ir_sh_reg <= `BSI_IR_CAPTURE;
                ST_SH_IR: ir_sh_reg <= {tdi_s2_reg, ir_sh_reg[`BSI_IR_LEN-1:1]};
                ST_UPD_IR: ir_reg <= ir_sh_reg;
                default: ir_sh_reg <= ir_sh_reg;
            endcase
        end
    end

    // Reserved codes are undefined; they fall to bypass here
    wire op_bsr = (ir_reg == `BSI_OP_EXTEST) || (ir_reg == `BSI_OP_SAMPLE)
        || (ir_reg == `BSI_OP_SAMPLE_Z);
    wire op_id = (ir_reg == `BSI_OP_IDCODE);

    // ****************************************
    // Identification and bypass registers
    // ****************************************
    reg [`BSI_ID_LEN-1:0] id_sh_reg;
    reg byp_reg;

    always @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            id_sh_reg <= {`BSI_ID_LEN{1'b0}};
            byp_reg <= 1'b0;
        end else if (tck_rise && state_reg == ST_CAP_DR) begin
            if (op_id) begin
                id_sh_reg <= ID_VALUE;
            end
            byp_reg <= `BSI_BYPASS_CAPTURE;
        end else if (tck_rise && state_reg == ST_SH_DR) begin
            if (op_id) begin
                id_sh_reg <= {tdi_s2_reg, id_sh_reg[`BSI_ID_LEN-1:1]};
            end
            byp_reg <= tdi_s2_reg;
        end
    end

    // ****************************************
    // Boundary scan register
    // ****************************************
    wire bsr_lsb;

    bsi_bsr #(
        .LEN(BSR_LEN),
        .OE_CELL(`BSI_OE_CELL)
    ) u_bsr (
        .i_mclk(i_mclk),
        .i_arst_n(i_arst_n),
        .i_tlr(in_tlr),
        .i_capture(tck_rise && state_reg == ST_CAP_DR && op_bsr),
        .i_shift(tck_rise && state_reg == ST_SH_DR && op_bsr),
        .i_update(tck_rise && state_reg == ST_UPD_DR && op_bsr),
        .i_tdi(tdi_s2_reg),
        .i_pins(pin_s2_reg),
        .o_lsb(bsr_lsb),
        .o_latch_reg(o_bsr_drive)
    );

    // ****************************************
    // Serial out and output bus control
    // ****************************************
    always @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_tdo <= 1'b0;
            o_tdo_oe <= 1'b0;
        end else if (tck_fall) begin
            o_tdo_oe <= (state_reg == ST_SH_IR) || (state_reg == ST_SH_DR);
            if (state_reg == ST_SH_IR) begin
                o_tdo <= ir_sh_reg[0];
            end else if (op_bsr) begin
                o_tdo <= bsr_lsb;
            end else if (op_id) begin
                o_tdo <= id_sh_reg[0];
            end else begin
                o_tdo <= byp_reg;
            end
        end
    end

    always @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_qbus_oe <= 1'b1;
            o_extest <= 1'b0;
        end else begin
            o_extest <= (ir_reg == `BSI_OP_EXTEST);
            if (ir_reg == `BSI_OP_SAMPLE_Z) begin
                o_qbus_oe <= 1'b0;
            end else if (ir_reg == `BSI_OP_EXTEST) begin
                o_qbus_oe <= o_bsr_drive[`BSI_OE_CELL];
            end else begin
                o_qbus_oe <= 1'b1;
            end
        end
    end

endmodule // bsi_tap
`default_nettype wire

// file: bsi_tap_checker.sv
// Purpose: Port timing checks for the test access port
// Assumes: Test clock half period spans four system clocks
// Notes: Bound to the top module below
`timescale 1ns/100ps
`default_nettype none
`include "bsi_defines.vh"
module bsi_tap_checker #(
    parameter BSR_LEN = 109
) (
    input wire logic i_mclk,
    input wire logic i_arst_n,
    input wire logic i_tck,
    input wire logic i_tms,
    input wire logic i_tdi,
    input wire logic [BSR_LEN-1:0] i_pins,
    input wire logic o_tdo,
    input wire logic o_tdo_oe,
    input wire logic o_qbus_oe,
    input wire logic o_extest,
    input wire logic [BSR_LEN-1:0] o_bsr_drive
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_arst_n);
    // ***
    // Test clock edges seen through two sync stages
    // ***
    sequence s_fall;
        !$past(i_tck, 3) && $past(i_tck, 4);
    endsequence
    sequence s_rise;
        $past(i_tck, 2) && $past(i_tck, 3);
    endsequence
    chk_tdo_at_fall: assert property ($changed(o_tdo) |-> s_fall)
        else $error("tdo moved off a fall");
    chk_oe_at_fall: assert property ($changed(o_tdo_oe) |-> s_fall)
        else $error("tdo enable moved off a fall");
    chk_oe_min_len: assert property ($rose(o_tdo_oe) |-> o_tdo_oe [*8])
        else $error("tdo enable too short");
    chk_latch_at_rise: assert property ($changed(o_bsr_drive) |-> s_rise)
        else $error("latches moved off a rise");
    chk_ir_at_rise: assert property ($changed(o_extest) |-> s_rise)
        else $error("instruction moved off a rise");
    chk_bus_at_rise: assert property ($changed(o_qbus_oe) |-> s_rise)
        else $error("bus enable moved off a rise");
    chk_bus_follows_cell: assert property (o_extest && $past(o_extest) |->
        o_qbus_oe == $past(o_bsr_drive[`BSI_OE_CELL]))
        else $error("bus enable differs from its cell");
    chk_reset_state: assert property (!$past(i_arst_n) |-> o_qbus_oe && !o_extest &&
        !o_tdo_oe && o_bsr_drive[`BSI_OE_CELL])
        else $error("wrong state after reset");
endmodule // bsi_tap_checker
bind bsi_tap bsi_tap_checker #(.BSR_LEN(BSR_LEN)) u_chk (.i_mclk(i_mclk), .i_arst_n(i_arst_n),
    .i_tck(i_tck), .i_tms(i_tms), .i_tdi(i_tdi), .i_pins(i_pins), .o_tdo(o_tdo),
    .o_tdo_oe(o_tdo_oe), .o_qbus_oe(o_qbus_oe), .o_extest(o_extest), .o_bsr_drive(o_bsr_drive));
`default_nettype wire

// file: bsi_tb.sv
// Purpose: Self-checking bench for the test access port
// Assumes: Controller model drives the test pins
// Notes: Serial results are checked from a queue
`timescale 1ns/100ps
`default_nettype none
`include "bsi_defines.vh"
`define TB_CHK(n, e, g) begin n_checks++; if ((e) !== (g)) begin err_count++; \
    $display("Error %s expected %h seen %h", n, e, g); end end
module testbench;
    logic i_mclk = 1'b0;
    logic i_arst_n = 1'b0;
    logic [108:0] i_pins = '0;
    wire logic tck, tms, tdi, tdo, tdo_oe, qbus_oe, extest;
    wire logic [108:0] drive;
    int err_count = 0;
    int n_checks = 0;
    logic [127:0] q_exp[$];
    logic [127:0] e, d, p;
    // Reserved codes are never loaded
    logic [2:0] codes[5] = '{`BSI_OP_EXTEST, `BSI_OP_IDCODE, `BSI_OP_SAMPLE_Z, `BSI_OP_SAMPLE,
        `BSI_OP_BYPASS};
    always #20 i_mclk = ~i_mclk;
    bsi_tap i_dut (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
        .i_pins(i_pins), .o_tdo(tdo), .o_tdo_oe(tdo_oe), .o_qbus_oe(qbus_oe), .o_extest(extest),
        .o_bsr_drive(drive));
    bsi_ctl i_ctl (.i_tdo(tdo), .o_tck(tck), .o_tms(tms), .o_tdi(tdi));
    // ***
    // Checking
    // ***
    always @(i_ctl.got) begin
        e = q_exp.pop_front();
        `TB_CHK("tdo", e, i_ctl.dout)
    end
    task automatic ir(input logic [2:0] c);
        q_exp.push_back({125'h0, `BSI_IR_CAPTURE});
        i_ctl.scan(1'b1, 3, {125'h0, c});
    endtask
    task automatic dr(input int n, input logic [127:0] din, input logic [127:0] x);
        q_exp.push_back(x);
        i_ctl.scan(1'b0, n, din);
    endtask
    function automatic logic [127:0] r4();
        return {$urandom, $urandom, $urandom, $urandom};
    endfunction
    task automatic stop_test();
        $display("Checks %0d, errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        #1000000;
        err_count++;
        stop_test();
    end
    initial begin
        d = $urandom(45);
        repeat (12) @(posedge i_mclk);
        @(negedge i_mclk) i_arst_n = 1'b1;
        `TB_CHK("bus_oe", 1'b1, qbus_oe)
        `TB_CHK("drive", 109'h1 << 108, drive)
        dr(32, r4(), `BSI_ID_VALUE);
        `TB_CHK("tdo_oe", 1'b0, tdo_oe)
        foreach (codes[k]) begin
            ir(codes[k]);
            `TB_CHK("extest", codes[k] == `BSI_OP_EXTEST, extest)
            `TB_CHK("bus_oe", codes[k] != `BSI_OP_SAMPLE_Z, qbus_oe)
        end
        d = r4();
        dr(40, d, {88'h0, d[38:0], `BSI_BYPASS_CAPTURE});
        p = r4();
        // Pins held still across each capture
        @(negedge i_mclk) i_pins = p[108:0];
        ir(`BSI_OP_SAMPLE);
        d = r4();
        d[108] = 1'b1;
        dr(109, d, {19'h0, p[108:0]});
        `TB_CHK("drive", d[108:0], drive)
        ir(`BSI_OP_EXTEST);
        `TB_CHK("bus_oe", 1'b1, qbus_oe)
        d[108] = 1'b0;
        dr(109, d, {19'h0, p[108:0]});
        `TB_CHK("bus_oe", 1'b0, qbus_oe)
        i_ctl.tlr();
        `TB_CHK("extest", 1'b0, extest)
        `TB_CHK("drive", {1'b1, d[107:0]}, drive)
        dr(32, r4(), `BSI_ID_VALUE);
        ir(`BSI_OP_SAMPLE_Z);
        `TB_CHK("bus_oe", 1'b0, qbus_oe)
        dr(109, d, {19'h0, p[108:0]});
        repeat (2) @(negedge i_mclk);
        stop_test();
    end
endmodule // testbench
`default_nettype wire
